// ---- tb_uart_baud_and_line_control.sv ----
// bench of the baud divisor and line format port
// assumes ubl_top and ubl_line_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_uart_baud_and_line_control;
  // ==========================================================
  // signals
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serial_receive_input;
  logic        serial_transmit_output;
  logic [15:0] divisor_whole_part;
  logic [5:0]  divisor_fraction_part;
  logic        parity_error_flag;
  logic [15:0] bit_clks = 16'h0010;
  logic [3:0]  sample_n = 4'hA;
  logic [11:0] got_bits;
  logic [15:0] got_gap;
  logic [15:0] got_cnt;
  logic [31:0] rdat;
  logic        rerr;
  int          mismatches = 0;
  int          tests_run = 0;
  // parity modes as {stick, even, enable}
  localparam logic [2:0] PM [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7, 3'h6};

  always #2 sys_clk = ~sys_clk;

  ubl_top u_dut (
    .sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_receive_input(serial_receive_input),
    .serial_transmit_output(serial_transmit_output),
    .divisor_whole_part(divisor_whole_part),
    .divisor_fraction_part(divisor_fraction_part),
    .parity_error_flag(parity_error_flag)
  );

  ubl_line_model u_line (
    .sys_clk(sys_clk), .line_in(serial_transmit_output),
    .line_out(serial_receive_input), .bit_clks(bit_clks),
    .sample_n(sample_n), .got_bits(got_bits), .got_gap(got_gap),
    .got_cnt(got_cnt)
  );

  // ==========================================================
  // tasks
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 4000);
    if (pready !== 1'b1) begin
      check(32'(pready), 32'h1);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_cnt(input int k);
    int n;
    n = 0;
    while (int'(got_cnt) < k && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(got_cnt), 32'(k));
  endtask

  task automatic wait_low;
    int n;
    n = 0;
    while (serial_transmit_output !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    apb(12'h024, 1'b0, 32'h0);
    check(rdat, 32'h0);
    apb(12'h028, 1'b0, 32'h0);
    check(rdat, 32'h0);
    apb(12'h02C, 1'b0, 32'h0);
    check(rdat, 32'h0);
    check(32'(divisor_whole_part), 32'h0);
    apb(12'h040, 1'b1, 32'h1);
    check(32'(rerr), 32'h1);
  endtask

  task automatic t_frames;
    logic [7:0]  d;
    logic [11:0] e;
    logic [11:0] k;
    logic        s2;
    int          nd;
    int          nb;
    int          base;
    for (int w = 0; w < 4; w++) begin
      for (int m = 0; m < 6; m++) begin
        nd = 5 + w;
        s2 = 1'(m ^ w);
        d = 8'hB3 & 8'((1 << nd) - 1);
        nb = 2 + nd + int'(PM[m][0]) + int'(s2);
        k = 12'((1 << nb) - 1);
        e = (12'hFFF << (nd + 1)) | {3'h0, d, 1'b0};
        if (PM[m][0]) begin
          e[nd + 1] = PM[m][2] ? ~PM[m][1] : (PM[m][1] ? ^d : ~^d);
        end
        repeat (32) @(posedge sys_clk);
        apb(12'h030, 1'b1, 32'h0);
        apb(12'h02C, 1'b1, {24'h0, PM[m][2], 2'(w), 1'b1, s2,
                            PM[m][1:0], 1'b0});
        apb(12'h030, 1'b1, 32'h1);
        sample_n <= 4'(nb);
        base = int'(got_cnt);
        apb(12'h000, 1'b1, 32'hB3);
        apb(12'h000, 1'b1, 32'hB3);
        wait_cnt(base + 2);
        check(32'(got_bits & k), 32'(e & k));
        // one idle clock between back-to-back frames
        check(32'(got_gap), 32'(nb * 16 + 1));
      end
    end
  endtask

  task automatic t_divisor;
    int base;
    apb(12'h028, 1'b1, 32'hFFFF_FFFF);
    apb(12'h028, 1'b0, 32'h0);
    check(rdat, 32'h3F);
    check(32'(divisor_fraction_part), 32'h0);
    apb(12'h028, 1'b1, 32'h0);
    apb(12'h024, 1'b1, 32'h2);
    repeat (8) @(posedge sys_clk);
    check(32'(divisor_whole_part), 32'h0);
    sample_n <= 4'hA;
    base = int'(got_cnt);
    apb(12'h000, 1'b1, 32'h5A);
    wait_low;
    apb(12'h02C, 1'b1, 32'hF4);
    check(32'(divisor_whole_part), 32'h0);
    while (divisor_whole_part !== 16'h0002 && int'(got_cnt) < base + 3) begin
      @(posedge sys_clk);
    end
    check(32'(got_cnt), 32'(base + 1));
    check(32'(divisor_whole_part), 32'h2);
    bit_clks <= 16'h0020;
    apb(12'h030, 1'b1, 32'h0);
    apb(12'h02C, 1'b1, 32'h7E);
    apb(12'h030, 1'b1, 32'h1);
  endtask

  task automatic t_rx;
    u_line.send({1'b1, 1'b0, 8'h5A, 1'b0}, 11);
    check(32'(parity_error_flag), 32'h0);
    u_line.send({1'b1, 1'b0, 8'h5B, 1'b0}, 11);
    repeat (64) @(posedge sys_clk);
    check(32'(parity_error_flag), 32'h1);
    apb(12'h018, 1'b0, 32'h0);
    check(32'(rdat[0]), 32'h0);
    apb(12'h000, 1'b0, 32'h0);
    check(rdat, 32'h05A);
    apb(12'h000, 1'b0, 32'h0);
    check(rdat, 32'h15B);
  endtask

  task automatic t_break;
    int base;
    sample_n <= 4'hC;
    base = int'(got_cnt);
    apb(12'h000, 1'b1, 32'hC3);
    wait_low;
    apb(12'h02C, 1'b1, 32'h7F);
    wait_cnt(base + 1);
    check(32'(got_bits), {20'h0, 12'hD86});
    // held longer than two twelve-bit characters
    repeat (800) @(posedge sys_clk);
    check(32'(serial_transmit_output), 32'h0);
    apb(12'h02C, 1'b1, 32'h7E);
    @(posedge sys_clk);
    check(32'(serial_transmit_output), 32'h1);
  endtask

  task automatic t_fifo;
    int base;
    int n;
    apb(12'h030, 1'b1, 32'h0);
    apb(12'h02C, 1'b1, 32'h6E);
    apb(12'h000, 1'b1, 32'h11);
    apb(12'h018, 1'b0, 32'h0);
    check(32'(rdat[5]), 32'h1);
    apb(12'h02C, 1'b1, 32'h7E);
    apb(12'h018, 1'b0, 32'h0);
    check(32'(rdat[5]), 32'h0);
    for (int i = 0; i < 31; i++) begin
      apb(12'h000, 1'b1, 32'(i));
    end
    apb(12'h018, 1'b0, 32'h0);
    check(32'(rdat[5]), 32'h1);
    base = int'(got_cnt);
    apb(12'h030, 1'b1, 32'h1);
    n = 0;
    do begin
      repeat (64) @(posedge sys_clk);
      apb(12'h018, 1'b0, 32'h0);
      n++;
    end while (rdat[7] !== 1'b1 && n < 400);
    check(32'(rdat[7]), 32'h1);
    wait_cnt(base + 32);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    t_frames;
    t_divisor;
    t_rx;
    t_break;
    t_fifo;
    stop_test;
  end

  initial begin
    repeat (80000) @(posedge sys_clk);
    mismatches++;
    stop_test;
  end
endmodule
`default_nettype wire

// ---- ubl_line_model.sv ----
// remote serial device: frame sender and mid-bit line sampler
// assumes the bench sets the bit period in clocks and the bits per frame
`timescale 1ns/1ps
`default_nettype none
module ubl_line_model (
  input  wire logic        sys_clk,
  input  wire logic        line_in,
  output logic             line_out,
  input  wire logic [15:0] bit_clks,
  input  wire logic [3:0]  sample_n,
  output logic [11:0]      got_bits,
  output logic [15:0]      got_gap,
  output logic [15:0]      got_cnt
);
  int t;
  int last;

  initial begin
    line_out = 1'b1;
    got_bits = 12'h000;
    got_gap = 16'h0000;
    got_cnt = 16'h0000;
    t = 0;
    last = 0;
  end

  always @(posedge sys_clk) t <= t + 1;

  // ==========================================================
  // sampler: start edge, then each bit at its middle
  always begin
    @(negedge line_in);
    got_gap = 16'(t - last);
    last = t;
    repeat (bit_clks / 2) @(posedge sys_clk);
    for (int i = 0; i < int'(sample_n); i++) begin
      got_bits[i] = line_in;
      if (i < int'(sample_n) - 1) begin
        repeat (bit_clks) @(posedge sys_clk);
      end
    end
    got_cnt = got_cnt + 16'h0001;
  end

  // ==========================================================
  // sender: bits go out LSB first, line stays at the last bit
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (bit_clks) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- ubl_pkg.sv ----
// state types of the serial transmitter and receiver
// assumes nothing of its surroundings
package ubl_pkg;

  typedef enum logic [4:0] {
    TX_IDLE   = 5'h01,
    TX_START  = 5'h02,
    TX_DATA   = 5'h04,
    TX_PARITY = 5'h08,
    TX_STOP   = 5'h10
  } ubl_tx_state_type;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'h01,
    RX_START  = 5'h02,
    RX_DATA   = 5'h04,
    RX_PARITY = 5'h08,
    RX_STOP   = 5'h10
  } ubl_rx_state_type;

endpackage

// ---- ubl_regs.svh ----
// register offsets, field positions, reset values and counts of the
// baud-rate and line-control port; included by the design file only
`ifndef UBL_REGS_SVH
`define UBL_REGS_SVH

// byte offsets on the register bus
`define UBL_OFF_DATA      12'h000
`define UBL_OFF_STATUS    12'h018
`define UBL_OFF_IBRD      12'h024
`define UBL_OFF_FBRD      12'h028
`define UBL_OFF_LCRH      12'h02C
`define UBL_OFF_CTRL      12'h030

// line format control fields
`define UBL_LCRH_BREAK     0
`define UBL_LCRH_PAR_ON    1
`define UBL_LCRH_PAR_EVEN  2
`define UBL_LCRH_STOP_TWO  3
`define UBL_LCRH_FIFO_ON   4
`define UBL_LCRH_LEN_LO    5
`define UBL_LCRH_LEN_HI    6
`define UBL_LCRH_PAR_STICK 7

// status fields
`define UBL_STAT_FE       0
`define UBL_STAT_PAR_ERR  1
`define UBL_STAT_BUSY     3
`define UBL_STAT_RXFE     4
`define UBL_STAT_TXFF     5
`define UBL_STAT_RXFF     6
`define UBL_STAT_TXFE     7

// control fields
`define UBL_CTRL_EN       0

// reset values
`define UBL_RST_IBRD      16'h0000
`define UBL_RST_FBRD      6'h00
`define UBL_RST_LCRH      8'h00
`define UBL_RST_CTRL      1'b0

// timing counts
`define UBL_FRAC_ONE      23'h000040
`define UBL_TICK_LAST     4'hF
`define UBL_TICK_MID      4'h7
`define UBL_LEN_BASE      3'h4
`define UBL_FIFO_DEPTH    32

`endif

// ---- ubl_top.sv ----
// serial port with baud divisor, line format control, fifos and apb slave
// assumes one 250 MHz clock, synchronous reset, asynchronous serial input
//
// Contract
// - divisor registers clear to zero on reset
// - zero integer divisor gives ratio one
// - new divisor applied only between characters
// - divisor takes effect only on line-control write
// - stick parity sends and checks inverted even-select
// - word length field selects five to eight bits
// - fifo enable off makes single-byte holding registers
// - two-stop select appends two stop bits
// - receiver checks just one stop bit
// - even select gives even count of ones
// - even select clear gives odd count
// - even select ignored while parity disabled
// - parity enable adds and checks parity bit
// - break finishes character then holds line low
// - receiver flags mismatching parity bit
`timescale 1ns/1ps
`default_nettype none
`include "ubl_regs.svh"

// ==========================================================
// fifo
module ubl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             single,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    next_count;
  wire              push;
  wire              pop;

  // single-byte holding register when fifo mode is off
  assign in_ready   = single ? (count == '0) : (count != CW'(DEPTH));
  assign out_valid  = (count != '0);
  assign out_data   = mem[rd_ptr];
  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign next_count = count + CW'(push) - CW'(pop);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
      rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
      count  <= next_count;
    end
  end
endmodule

// ==========================================================
// top
module ubl_top (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_receive_input,
  output logic             serial_transmit_output,
  output logic [15:0]      divisor_whole_part,
  output logic [5:0]       divisor_fraction_part,
  output logic             parity_error_flag
);
  import ubl_pkg::*;

  // ==========================================================
  // registers
  logic [15:0] ibrd;
  logic [5:0]  fbrd;
  logic [7:0]  lcrh;
  logic        port_enable;
  logic        pend;
  logic        fe_sticky;
  logic        parity_sticky;

  wire       send_break          = lcrh[`UBL_LCRH_BREAK];
  wire       parity_enable       = lcrh[`UBL_LCRH_PAR_ON];
  wire       even_parity_select  = lcrh[`UBL_LCRH_PAR_EVEN];
  wire       two_stop_bits       = lcrh[`UBL_LCRH_STOP_TWO];
  wire       fifo_en             = lcrh[`UBL_LCRH_FIFO_ON];
  wire [1:0] word_length         = lcrh[`UBL_LCRH_LEN_HI:`UBL_LCRH_LEN_LO];
  wire       stick_parity_select = lcrh[`UBL_LCRH_PAR_STICK];

  // ==========================================================
  // apb decode
  wire sel_data = (paddr == `UBL_OFF_DATA);
  wire sel_stat = (paddr == `UBL_OFF_STATUS);
  wire sel_ibrd = (paddr == `UBL_OFF_IBRD);
  wire sel_fbrd = (paddr == `UBL_OFF_FBRD);
  wire sel_lcrh = (paddr == `UBL_OFF_LCRH);
  wire sel_ctrl = (paddr == `UBL_OFF_CTRL);
  wire mapped   = sel_data | sel_stat | sel_ibrd | sel_fbrd | sel_lcrh
                | sel_ctrl;
  wire setup    = psel & ~penable;
  wire access   = psel & penable;

  logic       tx_in_ready;
  logic       tx_out_valid;
  logic [7:0] tx_out_data;
  logic [5:0] tx_count;
  logic       rx_in_ready;
  logic       rx_out_valid;
  logic [9:0] rx_out_data;
  logic       tx_idle;
  logic       rx_idle;
  logic       tx_pop;
  logic       rx_push;
  logic [9:0] rx_word;

  wire tx_in_valid = access & pwrite & sel_data;
  // tx fifo back-pressure stalls the bus write
  assign pready  = ~(tx_in_valid & ~tx_in_ready);
  assign pslverr = access & ~mapped;
  wire wr_en   = access & pwrite & pready & mapped;
  wire wr_stat = wr_en & sel_stat;
  wire wr_ibrd = wr_en & sel_ibrd;
  wire wr_fbrd = wr_en & sel_fbrd;
  wire wr_lcrh = wr_en & sel_lcrh;
  wire wr_ctrl = wr_en & sel_ctrl;
  wire rx_pop  = access & ~pwrite & sel_data;

  wire busy = ~tx_idle | tx_out_valid;
  wire [31:0] stat_word = {24'h000000, ~tx_out_valid, ~rx_in_ready,
                           ~tx_in_ready, ~rx_out_valid, busy, 1'b0,
                           parity_sticky, fe_sticky};
  wire [31:0] rd_mux =
    sel_data ? {22'h000000, rx_out_data} :
    sel_stat ? stat_word :
    sel_ibrd ? {16'h0000, ibrd} :
    sel_fbrd ? {26'h0000000, fbrd} :
    sel_lcrh ? {24'h000000, lcrh} :
    sel_ctrl ? {31'h00000000, port_enable} : 32'h00000000;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ibrd        <= `UBL_RST_IBRD;
      fbrd        <= `UBL_RST_FBRD;
      lcrh        <= `UBL_RST_LCRH;
      port_enable <= `UBL_RST_CTRL;
    end else begin
      ibrd        <= wr_ibrd ? pwdata[15:0] : ibrd;
      fbrd        <= wr_fbrd ? pwdata[5:0] : fbrd;
      lcrh        <= wr_lcrh ? pwdata[7:0] : lcrh;
      port_enable <= wr_ctrl ? pwdata[`UBL_CTRL_EN] : port_enable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fe_sticky     <= 1'b0;
      parity_sticky <= 1'b0;
    end else begin
      fe_sticky     <= (rx_push & rx_word[9]) | (fe_sticky & ~wr_stat);
      parity_sticky <= (rx_push & rx_word[8]) | (parity_sticky & ~wr_stat);
    end
  end
  assign parity_error_flag = parity_sticky;

  // ==========================================================
  // divisor apply
  // pending only from the line-control strobe
  wire apply = pend & tx_idle & rx_idle;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pend                  <= 1'b0;
      divisor_whole_part    <= `UBL_RST_IBRD;
      divisor_fraction_part <= `UBL_RST_FBRD;
    end else begin
      pend <= wr_lcrh | (pend & ~apply);
      if (apply) begin
        divisor_whole_part    <= ibrd;
        divisor_fraction_part <= fbrd;
      end
    end
  end

  // ==========================================================
  // baud tick
  logic [21:0] acc;
  wire  [21:0] div_full = {divisor_whole_part, divisor_fraction_part};
  wire  [22:0] acc_sum  = {1'b0, acc} + `UBL_FRAC_ONE;
  wire  [22:0] acc_diff = acc_sum - {1'b0, div_full};
  wire         hit      = (acc_sum >= {1'b0, div_full});
  // zero whole part runs at ratio one
  wire         ratio_one = (divisor_whole_part == 16'h0000);
  wire         baud_tick = ratio_one | hit;
  wire  [21:0] next_acc  = (ratio_one | apply) ? 22'h000000 :
                           hit ? acc_diff[21:0] : acc_sum[21:0];
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc <= 22'h000000;
    end else begin
      acc <= next_acc;
    end
  end

  // ==========================================================
  // fifos
  // depth one in character mode
  ubl_fifo #(.WIDTH(8), .DEPTH(`UBL_FIFO_DEPTH)) tx_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .single    (~fifo_en),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_out_data),
    .count     (tx_count)
  );

  ubl_fifo #(.WIDTH(10), .DEPTH(`UBL_FIFO_DEPTH)) rx_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .single    (~fifo_en),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (rx_word),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_out_data),
    .count     ()
  );

  // ==========================================================
  // transmitter
  ubl_tx_state_type tx_state;
  ubl_tx_state_type next_tx_state;
  logic [7:0] tx_buf;
  logic [3:0] tx_ticks;
  logic [2:0] tx_bit;
  logic       tx_second;
  logic       tx_level;

  // last data bit index from word length
  wire [2:0] tx_last   = 3'(word_length) + `UBL_LEN_BASE;
  wire [7:0] word_mask = 8'hFF >> (2'h3 - word_length);
  wire       tx_bit_end = baud_tick & (tx_ticks == `UBL_TICK_LAST);
  // stick parity, else even or odd
  wire       tx_par_bit = stick_parity_select ? ~even_parity_select :
                          (even_parity_select ? ^tx_buf : ~^tx_buf);
  // no new character while break is requested
  assign tx_idle = (tx_state == TX_IDLE);
  assign tx_pop  = tx_idle & port_enable & ~send_break & tx_out_valid;

  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE:   if (tx_pop) next_tx_state = TX_START;
      TX_START:  if (tx_bit_end) next_tx_state = TX_DATA;
      TX_DATA:   if (tx_bit_end && tx_bit == tx_last) begin
        next_tx_state = parity_enable ? TX_PARITY : TX_STOP;
      end
      TX_PARITY: if (tx_bit_end) next_tx_state = TX_STOP;
      TX_STOP:   if (tx_bit_end) begin
        next_tx_state = (two_stop_bits && !tx_second) ? TX_STOP : TX_IDLE;
      end
      default:   next_tx_state = TX_IDLE;
    endcase
  end

  always_comb begin
    case (tx_state)
      TX_IDLE:   tx_level = ~send_break;
      TX_START:  tx_level = 1'b0;
      TX_DATA:   tx_level = tx_buf[tx_bit];
      TX_PARITY: tx_level = tx_par_bit;
      TX_STOP:   tx_level = 1'b1;
      default:   tx_level = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_state               <= TX_IDLE;
      tx_buf                 <= 8'h00;
      tx_ticks               <= 4'h0;
      tx_bit                 <= 3'h0;
      tx_second              <= 1'b0;
      serial_transmit_output <= 1'b1;
    end else begin
      tx_state               <= next_tx_state;
      serial_transmit_output <= tx_level;
      if (tx_pop) begin
        tx_buf    <= tx_out_data & word_mask;
        tx_ticks  <= 4'h0;
        tx_bit    <= 3'h0;
        tx_second <= 1'b0;
      end else begin
        tx_ticks  <= baud_tick ? tx_ticks + 4'h1 : tx_ticks;
        tx_bit    <= (tx_bit_end && tx_state == TX_DATA) ?
                     tx_bit + 3'h1 : tx_bit;
        tx_second <= (tx_bit_end && tx_state == TX_STOP) | tx_second;
      end
    end
  end

  // ==========================================================
  // receiver
  ubl_rx_state_type rx_state;
  ubl_rx_state_type next_rx_state;
  logic       rx_s1;
  logic       rx_s2;
  logic       rx_s3;
  logic       rx_level;
  logic [7:0] rx_buf;
  logic [3:0] rx_ticks;
  logic [2:0] rx_bit;
  logic       rx_par_err;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_s3    <= 1'b1;
      rx_level <= 1'b1;
    end else begin
      rx_s1    <= serial_receive_input;
      rx_s2    <= rx_s1;
      rx_s3    <= rx_s2;
      rx_level <= (rx_s2 == rx_s3) ? rx_s3 : rx_level;
    end
  end

  assign rx_idle = (rx_state == RX_IDLE);
  wire rx_begin  = rx_idle & port_enable & ~rx_level;
  wire rx_mid    = baud_tick & (rx_ticks == `UBL_TICK_MID) &
                   (rx_state == RX_START);
  wire rx_sample = baud_tick & (rx_ticks == `UBL_TICK_LAST);
  // expected parity from stick and even selects
  wire rx_par_exp = stick_parity_select ? ~even_parity_select :
                    (even_parity_select ? ^rx_buf : ~^rx_buf);
  // single stop bit sampled, then done
  assign rx_push = rx_sample & (rx_state == RX_STOP);
  assign rx_word = {~rx_level, rx_par_err, rx_buf};

  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      RX_IDLE:   if (rx_begin) next_rx_state = RX_START;
      RX_START:  if (rx_mid) begin
        next_rx_state = rx_level ? RX_IDLE : RX_DATA;
      end
      RX_DATA:   if (rx_sample && rx_bit == tx_last) begin
        next_rx_state = parity_enable ? RX_PARITY : RX_STOP;
      end
      RX_PARITY: if (rx_sample) next_rx_state = RX_STOP;
      RX_STOP:   if (rx_sample) next_rx_state = RX_IDLE;
      default:   next_rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_state   <= RX_IDLE;
      rx_buf     <= 8'h00;
      rx_ticks   <= 4'h0;
      rx_bit     <= 3'h0;
      rx_par_err <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      if (rx_idle) begin
        rx_ticks   <= 4'h0;
        rx_bit     <= 3'h0;
        rx_buf     <= 8'h00;
        rx_par_err <= 1'b0;
      end else begin
        rx_ticks <= rx_mid ? 4'h0 :
                    baud_tick ? rx_ticks + 4'h1 : rx_ticks;
        if (rx_sample && rx_state == RX_DATA) begin
          rx_buf[rx_bit] <= rx_level;
          rx_bit         <= rx_bit + 3'h1;
        end
        if (rx_sample && rx_state == RX_PARITY) begin
          rx_par_err <= (rx_level != rx_par_exp);
        end
      end
    end
  end

  // ==========================================================
  // assertions
  divisor_reset_a: assert property (@(posedge sys_clk)
    reset |=> (ibrd == 16'h0000 && fbrd == 6'h00 &&
               divisor_whole_part == 16'h0000))
    else $error("divisor not cleared by reset");
  ratio_one_a: assert property (@(posedge sys_clk)
    disable iff (reset) (divisor_whole_part == 16'h0000) |-> baud_tick)
    else $error("zero divisor not ratio one");
  apply_idle_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    $changed(div_full) |-> $past(tx_idle && rx_idle && pend))
    else $error("divisor changed mid character");
  strobe_only_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    ((wr_ibrd || wr_fbrd) && !pend && !wr_lcrh) |=> $stable(div_full))
    else $error("divisor applied without line write");
  stick_parity_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    (tx_state == TX_PARITY && stick_parity_select) |=>
      serial_transmit_output == !$past(even_parity_select))
    else $error("stick parity level wrong");
  word_len_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    (tx_state == TX_DATA && next_tx_state != TX_DATA) |->
      tx_bit - `UBL_LEN_BASE == 3'(word_length))
    else $error("wrong data bit count");
  char_mode_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    (!fifo_en && tx_count != 6'h00) |-> !tx_in_ready)
    else $error("holding register took two bytes");
  two_stop_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    (tx_state == TX_STOP && tx_bit_end && two_stop_bits && !tx_second) |=>
      tx_state == TX_STOP)
    else $error("second stop bit missing");
  one_stop_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    rx_push |=> rx_state == RX_IDLE)
    else $error("receiver waited for second stop");
  parity_sum_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    (tx_state == TX_PARITY && !stick_parity_select) |=>
      (^{$past(tx_buf), serial_transmit_output}) ==
        !$past(even_parity_select))
    else $error("parity count of ones wrong");
  no_parity_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    (tx_state == TX_DATA && next_tx_state != TX_DATA && !parity_enable) |=>
      tx_state == TX_STOP)
    else $error("parity bit sent while disabled");
  break_low_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    (tx_idle && send_break) |=> !serial_transmit_output && tx_idle)
    else $error("break not holding line low");
  parity_flag_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    (rx_push && rx_par_err) |=> parity_sticky)
    else $error("parity error not flagged");
endmodule

`default_nettype wire
